// ### core/rx_format_defines.svh
// Register map, field positions and reset values of the receive formatter
`ifndef RX_FORMAT_DEFINES_SVH
`define RX_FORMAT_DEFINES_SVH

// Wishbone register byte offsets
`define REG_CTRL_OFFSET       4'h0
`define REG_STATUS_OFFSET     4'h4
`define REG_COUNT_OFFSET      4'h8

// Control register bits and reset value
`define CTRL_ENABLE_BIT       0
`define CTRL_FORCE_BULKY_BIT  1
`define CTRL_RESET_VALUE      2'h1

// Status register bit positions
`define STAT_BUSY_BIT         0
`define STAT_OUT_VALID_BIT    1
`define STAT_ROUTE_BULKY_BIT  2
`define STAT_STALLED_BIT      3
`define STAT_STATE_LSB        8

// Count register halves
`define COUNT_CTRL_LSB        0
`define COUNT_BULKY_LSB       16

// First header quadlet: identifier on top, packet control below
`define HDR_ID_LSB            16
`define CTL_TAG_LSB           10
`define CTL_RETRY_LSB         8
`define CTL_TRANSACTION_TYPE_CODE_LSB         4
`define CTL_PRIO_LSB          0

// Trailer quadlet fields
`define TRL_PAD_LSB           24
`define TRL_SPEED_LSB         16
`define TRL_ACK_LSB           0

// Header lengths in quadlets, last index
`define HDR_LAST_SHORT        2'h2
`define HDR_LAST_LONG         2'h3

// Wishbone answer latency in clock cycles after the request is seen
`define WB_ACK_LATENCY        1

`endif

// ### core/rx_format_pkg.sv
// Types shared by the asynchronous receive formatter
package rx_format_pkg;

  // Transaction type codes of asynchronous packets
  typedef enum logic [3:0] {
    TC_WR_QUAD_REQ  = 4'h0,
    TC_WR_BLK_REQ   = 4'h1,
    TC_WR_RESP      = 4'h2,
    TC_RD_QUAD_REQ  = 4'h4,
    TC_RD_BLK_REQ   = 4'h5,
    TC_RD_QUAD_RESP = 4'h6,
    TC_RD_BLK_RESP  = 4'h7,
    TC_LOCK_REQ     = 4'h9,
    TC_LOCK_RESP    = 4'hb
  } transaction_type_code_e;

  // Speed codes of the arriving packet; 2'h3 is undefined
  typedef enum logic [1:0] {
    SPD_100 = 2'h0,
    SPD_200 = 2'h1,
    SPD_400 = 2'h2,
    SPD_UND = 2'h3
  } speed_e;

  // Retry codes, passed through untouched
  typedef enum logic [1:0] {
    RT_NEW     = 2'h0,
    RT_RETRY_X = 2'h1,
    RT_RETRY_A = 2'h2,
    RT_RETRY_B = 2'h3
  } retry_e;

  // Formatter sequencing, one-hot
  typedef enum logic [4:0] {
    S_IDLE        = 5'h01,
    S_TRAIL_FIRST = 5'h02,
    S_HEADER      = 5'h04,
    S_PAYLOAD     = 5'h08,
    S_TRAIL_LAST  = 5'h10
  } fsm_e;

  // One received packet as handed over by the packet receiver
  typedef struct packed {
    logic        route_bulky;
    logic [15:0] target_node_identifier;
    logic [5:0]  transaction_tag;
    retry_e      retry_code;
    logic [3:0]  transaction_type_code;
    logic [3:0]  prio_level;
    logic [15:0] sender_node_identifier;
    logic [15:0] target_offset_upper;
    logic [31:0] target_offset_lower;
    logic [31:0] quadlet_data;
    logic [15:0] payload_byte_count;
    logic [15:0] extended_code;
    speed_e      speed;
    logic [3:0]  returned_acknowledge;
  } rx_packet_s;

  // One quadlet toward the receive FIFOs
  typedef struct packed {
    logic [31:0] data;
    logic        first;
    logic        last;
    logic        bulky;
  } fifo_word_s;

endpackage

// ### core/quadlet_pad.sv
// Zero fill of the unused trailing bytes of a payload quadlet
module quadlet_pad
  import rx_format_pkg::*;
(
  input  wire logic [31:0] data_in,
  input  wire logic [2:0]  keep_bytes,
  output logic      [31:0] data_out
);

  // Byte 0 sits in bits 31:24; bytes at or past keep_bytes become zero
  for (genvar b = 0; b < 4; b++) begin : g_byte
    assign data_out[31-8*b -: 8] =
      (3'(b) < keep_bytes) ? data_in[31-8*b -: 8] : 8'h00;
  end

endmodule

// ### core/async_receive_packet_formatter.sv
// Formatter of received asynchronous packets into receive FIFO quadlets
// Contract
// - First quadlet: target identifier high 16 bits, packet control low 16.
// - Target identifier is 10-bit bus number joined to 6-bit node number.
// - Second quadlet upper half holds the sender node identifier.
// - 48-bit target offset: upper part in quadlet two, lower in three.
// - Quadlet packets carry data quadlet only for writes and read responses.
// - Block payload for write requests, read responses and lock requests and responses.
// - A trailer is built for each packet; last for the control FIFO.
// - Bulky FIFO packets get the trailer first, before the header.
// - Trailer-first order applies to block packets into bulky FIFOs too.
// - Two-bit retry code passes through with its encoding unchanged.
// - Trailer speed field reports arrival speed 100, 200 or 400.
// - Trailer acknowledge field holds the acknowledge this node returned.
// - Transaction tag is stored unchanged for request matching.
// - Payload byte 0 leads quadlet; last quadlet zero padded.
// - Trailer counts zero-filled padding bytes of the last quadlet.
// - Block byte count covers payload only, kept as received.
`include "rx_format_defines.svh"

module async_receive_packet_formatter
  import rx_format_pkg::*;
#(
  parameter int QCNT_W = 15
)
(
  input  wire logic        mclk,
  input  wire logic        rst,
  // Classic Wishbone slave
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_cyc_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Packet descriptor from the receiver
  input  wire logic        pkt_valid,
  input  rx_packet_s       pkt,
  output logic             pkt_ready,
  // Payload quadlets from the receiver
  input  wire logic        pay_valid,
  input  wire logic [31:0] pay_data,
  output logic             pay_ready,
  // Quadlets toward the receive FIFOs
  output logic             q_valid,
  output fifo_word_s       q_word,
  input  wire logic        q_ready
);

  // A 16-bit byte count needs up to 16384 quadlets
  if (QCNT_W < 15 || QCNT_W > 24) begin : g_check
    $error("QCNT_W must lie between 15 and 24");
  end

  fsm_e              state;
  fsm_e              next_state;
  rx_packet_s        cur;
  logic              bulky;
  logic [1:0]        hdr_idx;
  logic [QCNT_W-1:0] pay_left;
  logic [1:0]        ctrl_bits;
  logic [15:0]       count_ctrl;
  logic [15:0]       count_bulky;

  logic              accept;
  logic              out_free;
  logic              emit;
  logic              emit_last;
  logic [31:0]       emit_data;
  logic              is_block;
  logic              has_quad_data;
  logic              block_data;
  logic [1:0]        hdr_last;
  logic [QCNT_W-1:0] pay_quads;
  logic [1:0]        pad_count;
  logic [2:0]        keep_bytes;
  logic [31:0]       padded;
  logic [31:0]       trailer;
  logic [31:0]       hdr_word;
  logic              wb_req;
  logic              wb_write;
  logic [31:0]       reg_rdata;
  logic              count_clear;

  // Packet classification from the stored type code
  // type code decides
  always_comb begin
    is_block      = 1'b0;
    has_quad_data = 1'b0;
    block_data    = 1'b0;
    unique case (cur.transaction_type_code)
      TC_WR_QUAD_REQ, TC_RD_QUAD_RESP: begin
        has_quad_data = 1'b1;
      end
      TC_WR_BLK_REQ, TC_RD_BLK_RESP, TC_LOCK_REQ, TC_LOCK_RESP: begin
        is_block   = 1'b1;
        block_data = 1'b1;
      end
      TC_RD_BLK_REQ: begin
        // Requested length only, no data follows
        is_block = 1'b1;
      end
      // Write responses, quadlet reads and unknown codes: header only
      default: is_block = 1'b0;
    endcase
  end

  // Header length and payload size derived from the stored packet
  // payload-only count
  assign hdr_last  = (is_block || has_quad_data) ? `HDR_LAST_LONG
                                                 : `HDR_LAST_SHORT;
  assign pay_quads = block_data
                   ? QCNT_W'((17'(cur.payload_byte_count) + 17'h3) >> 2)
                   : '0;
  assign pad_count = block_data ? (2'h0 - cur.payload_byte_count[1:0])
                                : 2'h0;
  assign keep_bytes = (pay_left == QCNT_W'(1) &&
                       cur.payload_byte_count[1:0] != 2'h0)
                    ? {1'b0, cur.payload_byte_count[1:0]} : 3'h4;

  quadlet_pad u_pad (
    .data_in    (pay_data),
    .keep_bytes (keep_bytes),
    .data_out   (padded)
  );

  // Reception trailer, built from what the receiver reported
  always_comb begin
    trailer = 32'h0000_0000;
    trailer[`TRL_PAD_LSB +: 2] = pad_count;
    trailer[`TRL_SPEED_LSB +: 2] = cur.speed;
    trailer[`TRL_ACK_LSB +: 4] = cur.returned_acknowledge;
  end

  // Header quadlets in stored order
  always_comb begin
    unique case (hdr_idx)
      2'h0: begin
        hdr_word = {cur.target_node_identifier,
                    cur.transaction_tag,
                    cur.retry_code,
                    cur.transaction_type_code,
                    cur.prio_level};
      end
      2'h1: begin
        hdr_word = {cur.sender_node_identifier, cur.target_offset_upper};
      end
      2'h2: begin
        hdr_word = cur.target_offset_lower;
      end
      default: begin
        // block length word, or the quadlet's data
        hdr_word = is_block ? {cur.payload_byte_count, cur.extended_code}
                            : cur.quadlet_data;
      end
    endcase
  end

  // A new packet is taken only when idle, so packets never interleave
  // one packet at a time
  assign accept    = (state == S_IDLE) && pkt_valid &&
                     ctrl_bits[`CTRL_ENABLE_BIT];
  assign pkt_ready = (state == S_IDLE) && ctrl_bits[`CTRL_ENABLE_BIT];
  assign out_free  = !q_valid || q_ready;
  assign pay_ready = (state == S_PAYLOAD) && out_free;

  // Sequencing of trailer, header, payload and trailer
  always_comb begin
    next_state = state;
    emit       = 1'b0;
    emit_last  = 1'b0;
    emit_data  = 32'h0000_0000;
    unique case (state)
      S_IDLE: begin
        if (accept) begin
          next_state = (pkt.route_bulky ||
                        ctrl_bits[`CTRL_FORCE_BULKY_BIT])
                     ? S_TRAIL_FIRST : S_HEADER;
        end
      end
      S_TRAIL_FIRST: begin
        emit      = out_free;
        emit_data = trailer;
        if (out_free) begin
          next_state = S_HEADER;
        end
      end
      S_HEADER: begin
        emit      = out_free;
        emit_data = hdr_word;
        if (out_free && hdr_idx == hdr_last) begin
          if (pay_quads != '0) begin
            next_state = S_PAYLOAD;
          end else if (bulky) begin
            emit_last  = 1'b1;
            next_state = S_IDLE;
          end else begin
            next_state = S_TRAIL_LAST;
          end
        end
      end
      S_PAYLOAD: begin
        emit      = out_free && pay_valid;
        emit_data = padded;
        if (emit && pay_left == QCNT_W'(1)) begin
          emit_last  = bulky;
          next_state = bulky ? S_IDLE : S_TRAIL_LAST;
        end
      end
      S_TRAIL_LAST: begin
        emit       = out_free;
        emit_last  = out_free;
        emit_data  = trailer;
        if (out_free) begin
          next_state = S_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Packet capture; held stable for the whole packet
  always_ff @(posedge mclk) begin
    if (rst) begin
      cur   <= '0;
      bulky <= 1'b0;
    end else if (accept) begin
      cur   <= pkt;
      bulky <= pkt.route_bulky || ctrl_bits[`CTRL_FORCE_BULKY_BIT];
    end
  end

  // Header quadlet index
  always_ff @(posedge mclk) begin
    if (rst) begin
      hdr_idx <= 2'h0;
    end else if (state != S_HEADER) begin
      hdr_idx <= 2'h0;
    end else if (out_free) begin
      hdr_idx <= hdr_idx + 2'h1;
    end
  end

  // Remaining payload quadlets; loaded on every header cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      pay_left <= '0;
    end else if (state == S_HEADER) begin
      pay_left <= pay_quads;
    end else if (state == S_PAYLOAD && emit) begin
      pay_left <= pay_left - QCNT_W'(1);
    end
  end

  // Output word register; data always comes from flip-flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      q_valid <= 1'b0;
      q_word  <= '0;
    end else if (emit) begin
      q_valid       <= 1'b1;
      q_word.data   <= emit_data;
      q_word.last   <= emit_last;
      q_word.bulky  <= bulky;
      q_word.first  <= (state == S_TRAIL_FIRST) ||
                       (state == S_HEADER && hdr_idx == 2'h0 && !bulky);
    end else if (q_ready) begin
      q_valid <= 1'b0;
    end
  end

  // Wishbone request, answered one cycle later
  assign wb_req   = wb_cyc_i && wb_stb_i;
  assign wb_write = wb_req && wb_we_i && wb_ack_o;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
    end
  end

  // Read mux; unmapped offsets answer with zero
  always_comb begin
    reg_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      `REG_CTRL_OFFSET: reg_rdata[1:0] = ctrl_bits;
      `REG_STATUS_OFFSET: begin
        reg_rdata[`STAT_BUSY_BIT]        = (state != S_IDLE);
        reg_rdata[`STAT_OUT_VALID_BIT]   = q_valid;
        reg_rdata[`STAT_ROUTE_BULKY_BIT] = bulky;
        reg_rdata[`STAT_STALLED_BIT]     = pkt_valid && !pkt_ready;
        reg_rdata[`STAT_STATE_LSB +: 5]  = state;
      end
      `REG_COUNT_OFFSET: reg_rdata = {count_bulky, count_ctrl};
      default:           reg_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is latched together with the rising ack
  always_ff @(posedge mclk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_ack_o) begin
      wb_dat_o <= reg_rdata;
    end
  end

  // Control writes land at the edge that sees ack; low byte lane only
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_bits <= `CTRL_RESET_VALUE;
    end else if (wb_write && wb_adr_i == `REG_CTRL_OFFSET && wb_sel_i[0]) begin
      ctrl_bits <= wb_dat_i[1:0];
    end
  end

  // Packet counters; a completion in the clearing cycle is still counted
  assign count_clear = wb_write && wb_adr_i == `REG_COUNT_OFFSET;

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_ctrl  <= 16'h0000;
      count_bulky <= 16'h0000;
    end else begin
      if (count_clear) begin
        count_ctrl  <= {15'h0, emit_last && !bulky};
        count_bulky <= {15'h0, emit_last && bulky};
      end else if (emit_last) begin
        if (bulky) begin
          count_bulky <= count_bulky + 16'h0001;
        end else begin
          count_ctrl <= count_ctrl + 16'h0001;
        end
      end
    end
  end

endmodule

// ### verification/rx_fmt_checker_sva.sv
// Port-level assertions for the asynchronous receive formatter
module rx_fmt_checker
  import rx_format_pkg::*;
#(
  parameter int QCNT_W = 15
)
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        wb_stb_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_ack_o,
  input wire logic        pkt_valid,
  input rx_packet_s       pkt,
  input wire logic        pkt_ready,
  input wire logic        pay_valid,
  input wire logic [31:0] pay_data,
  input wire logic        pay_ready,
  input wire logic        q_valid,
  input fifo_word_s       q_word,
  input wire logic        q_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Handshake steps that the properties build on
  sequence s_wb_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_accept;
    pkt_valid && pkt_ready;
  endsequence
  sequence s_pay;
    pay_valid && pay_ready;
  endsequence
  // Output slot free: the held word leaves or none is held
  sequence s_slot_free;
    !q_valid || q_ready;
  endsequence

  // Bus answer comes exactly one cycle after the request
  wb_answer_a:
    assert property (s_wb_req |=> wb_ack_o)
    else $error("bus answer not one cycle after request");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer held longer than one cycle");
  word_hold_a:
    assert property (q_valid && !q_ready |=> q_valid && $stable(q_word))
    else $error("stalled word changed or vanished");
  accept_busy_a:
    assert property (s_accept |=> !pkt_ready)
    else $error("second packet taken while one is in progress");
  first_word_a:
    assert property (s_accept ##1 s_slot_free |=> q_valid && q_word.first &&
      (q_word.bulky ?
        q_word.data[3:0] == $past(pkt.returned_acknowledge, 2) &&
        q_word.data[17:16] == $past(pkt.speed, 2) :
        q_word.data[31:16] == $past(pkt.target_node_identifier, 2)))
    else $error("leading word of packet wrong");
  trailer_clean_a:
    assert property (q_valid && q_word.first && q_word.bulky |->
      q_word.data[31:26] == 6'h0 && q_word.data[23:18] == 6'h0 &&
      q_word.data[15:4] == 12'h0)
    else $error("unused trailer bits not zero");
  payload_lead_a:
    assert property (s_pay |=> q_valid && !q_word.first &&
      q_word.data[31:24] == $past(pay_data[31:24]))
    else $error("payload byte 0 not leading the quadlet");
  idle_quiet_a:
    assert property (pkt_ready && q_valid |-> q_word.last)
    else $error("new packet offered before previous one closed");
endmodule

bind async_receive_packet_formatter rx_fmt_checker #(.QCNT_W(QCNT_W)) chk_u (
  .mclk(mclk), .rst(rst), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
  .wb_ack_o(wb_ack_o), .pkt_valid(pkt_valid), .pkt(pkt),
  .pkt_ready(pkt_ready), .pay_valid(pay_valid), .pay_data(pay_data),
  .pay_ready(pay_ready), .q_valid(q_valid), .q_word(q_word),
  .q_ready(q_ready)
);

// ### verification/rx_fifo_host.sv
// Host-side reader of the receive FIFOs, prompt or stalling
module rx_fifo_host
  import rx_format_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic slow,
  input  wire logic q_valid,
  input  fifo_word_s q_word,
  output logic      q_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lfsr;
  fifo_word_s got[$];

  // Slow mode stalls about half the cycles to exercise back-pressure
  always_ff @(posedge mclk) begin
    if (rst) begin
      lfsr    <= 8'h5a;
      q_ready <= 1'b0;
    end else begin
      lfsr    <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      q_ready <= !slow || lfsr[0];
    end
  end

  // A word is stored only at the edge that completes its handshake
  always @(posedge mclk) begin
    if (!rst && q_valid && q_ready)
      got.push_back(q_word);
  end
endmodule

// ### verification/tb_async_receive_packet_formatter.sv
// Self-checking bench of the asynchronous receive formatter
module tb_async_receive_packet_formatter
  import rx_format_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o;
  logic        pkt_valid, pkt_ready, pay_valid, pay_ready;
  logic        q_valid, q_ready, slow, fb;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, pay_data, seed, rd;
  logic [31:0] payw [16];
  logic [4:0]  pidx, n_pay;
  rx_packet_s  pkt;
  fifo_word_s  q_word;
  int          n_errors, cmp_count, cnt_c, cnt_b;
  logic [31:0] exp_q[$];
  logic [3:0]  tcs [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7,
                           4'h9, 4'hb};

  async_receive_packet_formatter #(.QCNT_W(15)) dut_u (
    .mclk(mclk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_stb_i(wb_stb_i),
    .wb_cyc_i(wb_cyc_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pkt_valid(pkt_valid), .pkt(pkt), .pkt_ready(pkt_ready),
    .pay_valid(pay_valid), .pay_data(pay_data), .pay_ready(pay_ready),
    .q_valid(q_valid), .q_word(q_word), .q_ready(q_ready));
  rx_fifo_host host_u (.mclk(mclk), .rst(rst), .slow(slow),
    .q_valid(q_valid), .q_word(q_word), .q_ready(q_ready));

  // Free-running 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Payload offered in order; index restarts on each accepted packet
  always @(posedge mclk) begin
    if (rst || (pkt_valid && pkt_ready)) pidx = 5'h0;
    else if (pay_valid && pay_ready) pidx = pidx + 5'h1;
    pay_valid <= pidx < n_pay;
    pay_data  <= payw[pidx[3:0]];
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic [3:0] a, input logic we,
                    input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge mclk);
    wb_adr_i <= a;
    wb_we_i  <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      check(1'b0, 1'b1, "bus timeout");
      tally_and_finish();
    end
  endtask

  // Expected quadlets of one packet, in FIFO order
  function automatic void exp_pkt(input rx_packet_s p, input logic b);
    logic [3:0]  t;
    logic        blk;
    logic [1:0]  pad;
    logic [31:0] trl;
    int          nq;
    t   = p.transaction_type_code;
    blk = t inside {4'h1, 4'h5, 4'h7, 4'h9, 4'hb};
    nq  = t inside {4'h0, 4'h6} ? 1 : 0;
    if (t inside {4'h1, 4'h7, 4'h9, 4'hb})
      nq = (int'(p.payload_byte_count) + 3) / 4;
    pad = nq > 0 && blk ? 2'(4 - p.payload_byte_count % 4) : 2'h0;
    trl = {6'h0, pad, 6'h0, p.speed, 12'h0, p.returned_acknowledge};
    exp_q = {};
    if (b) exp_q.push_back(trl);
    exp_q.push_back({p.target_node_identifier, p.transaction_tag,
                     p.retry_code, t, p.prio_level});
    exp_q.push_back({p.sender_node_identifier, p.target_offset_upper});
    exp_q.push_back(p.target_offset_lower);
    if (blk) exp_q.push_back({p.payload_byte_count, p.extended_code});
    for (int i = 0; i < nq; i++)
      exp_q.push_back(!blk ? p.quadlet_data : i < nq - 1 || pad == 0 ?
        payw[i] : payw[i] & ~((32'h1 << (8 * pad)) - 32'h1));
    if (!b) exp_q.push_back(trl);
  endfunction

  // One packet through descriptor, payload and FIFO, then compared
  task automatic run_pkt(input logic [3:0] t, input logic bk, input int k);
    rx_packet_s p;
    int         base, n;
    p = rx_packet_s'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
    p.transaction_type_code = t;
    p.route_bulky = bk;
    p.prio_level = 4'h0;
    p.retry_code = retry_e'(k[1:0]);
    p.speed = speed_e'(2'(k % 3));
    p.payload_byte_count = 16'(k % 14);
    if (t == 4'hb) p.target_offset_upper[11:0] = 12'h0;
    for (int j = 0; j < 16; j++) payw[j] <= rnd();
    n = t inside {4'h1, 4'h7, 4'h9, 4'hb} ? (k % 14 + 3) / 4 : 0;
    n_pay <= 5'(n);
    pkt <= p;
    pkt_valid <= 1'b1;
    base = host_u.got.size();
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pkt_ready !== 1'b1 && n < 50);
    pkt_valid <= 1'b0;
    if (pkt_ready !== 1'b1) begin
      check(1'b0, 1'b1, "packet never taken");
      tally_and_finish();
    end
    exp_pkt(p, bk | fb);
    n = 0;
    while (host_u.got.size() < base + exp_q.size() && n < 300) begin
      @(posedge mclk);
      n++;
    end
    if (host_u.got.size() < base + exp_q.size()) begin
      check(1'b0, 1'b1, "packet never completed");
      tally_and_finish();
    end
    foreach (exp_q[i]) begin
      check(host_u.got[base+i].data, exp_q[i], "word");
      check(host_u.got[base+i].first, i == 0, "first");
      check(host_u.got[base+i].last, i == exp_q.size() - 1, "last");
      check(host_u.got[base+i].bulky, bk | fb, "bulky");
    end
    if (bk | fb) cnt_b++;
    else cnt_c++;
  endtask

  initial begin
    {wb_we_i, wb_stb_i, wb_cyc_i, pkt_valid, slow, fb} = '0;
    {wb_adr_i, wb_dat_i, n_pay} = '0;
    wb_sel_i = 4'hf;
    pkt = '0;
    rst = 1'b1;
    seed = 32'h18;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    wb(4'h0, 1'b0, 32'h0, rd);
    check(rd, 32'h1, "ctrl reset value");
    wb(4'hc, 1'b1, 32'hffffffff, rd);
    wb(4'hc, 1'b0, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    wb(4'h4, 1'b0, 32'h0, rd);
    check(rd, {19'h0, S_IDLE, 8'h00}, "status idle");
    wb(4'h8, 1'b1, 32'h0, rd);
    wb(4'h0, 1'b1, 32'h0, rd);
    @(posedge mclk);
    check(pkt_ready, 1'b0, "disabled still ready");
    pkt_valid <= 1'b1;
    wb(4'h4, 1'b0, 32'h0, rd);
    check(rd, {19'h0, S_IDLE, 8'h08}, "status stalled");
    pkt_valid <= 1'b0;
    wb(4'h0, 1'b1, 32'h1, rd);
    $display("test registers done");
    // every transaction code on both routes
    for (int k = 0; k < 18; k++) run_pkt(tcs[k % 9], k >= 9, k);
    $display("test code sweep done");
    wb(4'h0, 1'b1, 32'h3, rd);
    fb = 1'b1;
    wb(4'h0, 1'b0, 32'h0, rd);
    check(rd, 32'h3, "ctrl readback");
    for (int k = 0; k < 9; k++) run_pkt(tcs[k], 1'b0, k + 5);
    wb(4'h0, 1'b1, 32'h1, rd);
    fb = 1'b0;
    $display("test forced bulky done");
    for (int k = 0; k < 40; k++) begin
      rd = rnd();
      slow <= rd[0];
      run_pkt(tcs[rd[11:8] % 9], rd[4], k);
    end
    $display("test random stalls done");
    wb(4'h8, 1'b0, 32'h0, rd);
    check(rd, {16'(cnt_b), 16'(cnt_c)}, "packet counts");
    tally_and_finish();
  end
endmodule
